// >>> bench/icor_bus_model.sv
// Purpose: Behavioural internal bus memory for the cache bench.
// Assumes: Requests are seen one cycle edge plus one step late.
// Notes:   Read data is a fixed function of the word address.
`timescale 1ns/100ps
module icor_bus_model (
    // Requests from the cache
    input wire logic clock_i,
    input wire logic req_i,
    input wire logic we_i,
    input wire logic burst_i,
    input wire logic [31:0] addr_i,
    // Stall length and answers
    input wire logic [3:0] wait_i,
    output logic ack_o,
    output logic [31:0] rdata_o,
    output logic [15:0] bursts_o
);
    int beat;
    logic [31:0] wa;
    // One transfer at a time; the data line shows the inverse between beats
    // so that a stale sample can never pass for a real word.
    initial begin
        ack_o = 1'b0;
        rdata_o = 32'h0;
        bursts_o = 16'h0;
        forever begin
            @(posedge clock_i);
            #1;
            if (req_i) begin
                bursts_o = bursts_o + 16'(burst_i);
                for (beat = 0; beat < (burst_i ? 4 : 1); beat++) begin
                    repeat (wait_i) @(posedge clock_i);
                    wa = addr_i;
                    wa[3:2] = addr_i[3:2] + beat[1:0];
                    #1 ack_o = 1'b1;
                    rdata_o = we_i ? ~rdata_o : wa ^ 32'h5A5AC3C3;
                    @(posedge clock_i);
                    #1 ack_o = 1'b0;
                    rdata_o = ~rdata_o;
                end
                while (req_i) begin
                    @(posedge clock_i);
                    #1;
                end
            end
        end
    end
endmodule : icor_bus_model

// >>> bench/icor_cache_sva.sv
// Purpose: Port-level checks for the instruction cache.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes:   Bound to every icor_cache instance below.
`timescale 1ns/100ps
module icor_cache_sva (
    // Clock, reset and enables
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic icache_enable_bit_i,
    input wire logic dcache_enable_bit_i,
    // Fetch port and bus
    input wire logic fetch_req_i,
    input wire logic fetch_ack_o,
    input wire logic [31:0] fetch_data_o,
    input wire logic bus_req_o,
    input wire logic bus_we_o,
    input wire logic bus_burst_o,
    input wire logic [31:0] bus_addr_o,
    input wire logic bus_ack_i,
    input wire logic [31:0] bus_rdata_i,
    // RAM port
    input wire logic ram_req_i,
    input wire logic ram_ack_o,
    input wire logic ram_err_o
);
    logic [1:0] beats;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // Beats seen in the current transfer; the fourth wraps it back to zero.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i || !bus_req_o) begin
            beats <= 2'h0;
        end else if (bus_ack_i) begin
            beats <= beats + 2'h1;
        end
    end
    // Fetch answers.
    a_ack_pulse: assert property (fetch_ack_o |=> !fetch_ack_o)
        else $error("fetch ack held longer than one cycle");
    a_ack_cause: assert property (fetch_ack_o |-> $past(fetch_req_i))
        else $error("fetch ack without a request");
    a_first_fwd: assert property (bus_req_o && !bus_we_o && bus_ack_i &&
        beats == 2'h0 |=> fetch_ack_o && fetch_data_o == $past(bus_rdata_i))
        else $error("first bus word not forwarded next cycle");
    // Bus requests hold until the last beat, four for a burst.
    a_bus_hold: assert property (bus_req_o && !(bus_ack_i && (!bus_burst_o ||
        beats == 2'h3)) |=> bus_req_o && $stable(bus_addr_o) &&
        $stable(bus_burst_o) && $stable(bus_we_o))
        else $error("bus request changed before its last beat");
    a_bus_release: assert property (bus_req_o && bus_ack_i && (!bus_burst_o ||
        beats == 2'h3) |=> !bus_req_o)
        else $error("bus request kept after the last beat");
    a_burst_form: assert property ($rose(bus_req_o) && bus_burst_o |->
        !bus_we_o && !bus_addr_o[31] && bus_addr_o[1:0] == 2'h0)
        else $error("burst malformed or non-cacheable");
    a_nc_single: assert property ($rose(bus_req_o) && !bus_we_o &&
        (bus_addr_o[31] || !icache_enable_bit_i) |-> !bus_burst_o)
        else $error("uncached fetch issued a burst");
    // Reset and RAM port.
    a_reset_quiet: assert property (disable iff (1'b0) !rst_n_i |=>
        !fetch_ack_o && !bus_req_o && !ram_ack_o)
        else $error("outputs active after a reset edge");
    a_ram_ack: assert property (ram_req_i && !ram_ack_o |=> ram_ack_o)
        else $error("RAM access not answered next cycle");
    a_ram_none: assert property (ram_req_i && !ram_ack_o &&
        icache_enable_bit_i && dcache_enable_bit_i |=> ram_err_o)
        else $error("RAM reachable with both caches on");
    c_burst: cover property (bus_req_o && bus_burst_o && bus_ack_i &&
        beats == 2'h3);
    c_nc: cover property ($rose(bus_req_o) && bus_addr_o[31] && !bus_we_o);
    c_ram_err: cover property (ram_ack_o && ram_err_o);
endmodule : icor_cache_sva

bind icor_cache icor_cache_sva i_sva (.*);

// >>> bench/instruction_cache_onchip_ram_test.sv
// Purpose: Self-checking bench for the instruction cache.
// Assumes: Inputs change one step after the rising edge.
// Notes:   Expected results queue up; a watcher compares them.
`timescale 1ns/100ps
module instruction_cache_onchip_ram_test;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic icache_enable_bit_i = 1'b0;
    logic dcache_enable_bit_i = 1'b0;
    logic fill_lock_i = 1'b0;
    logic unlock_all_i = 1'b0;
    logic fetch_req_i = 1'b0;
    logic [31:0] fetch_addr_i = 32'h0;
    logic wb_req_i = 1'b0;
    logic [31:0] wb_addr_i = 32'h0;
    logic [31:0] wb_data_i = 32'h0;
    logic ram_req_i = 1'b0;
    logic ram_we_i = 1'b0;
    logic [31:0] ram_addr_i = 32'h0;
    logic [31:0] ram_wdata_i = 32'h0;
    logic fetch_ack_o, bus_req_o, bus_we_o, bus_burst_o, bus_ack_i;
    logic wb_ready_o, ram_ack_o, ram_err_o;
    logic [31:0] fetch_data_o, bus_addr_o, bus_wdata_o, bus_rdata_i;
    logic [31:0] ram_rdata_o, a, b, c, e, f, g, h;
    logic [3:0] bus_wait = 4'h0;
    logic [15:0] bursts;
    logic [7:0] ix;
    logic [33:0] r;
    logic [31:0] fetch_q[$];
    logic [63:0] store_q[$];
    logic [33:0] ram_q[$];
    int err_total = 0;
    int total_checks = 0;

    initial forever #25 clock_i = ~clock_i;
    icor_cache i_dut (.*);
    icor_bus_model i_bus (.clock_i(clock_i), .req_i(bus_req_o),
        .we_i(bus_we_o), .burst_i(bus_burst_o), .addr_i(bus_addr_o),
        .wait_i(bus_wait), .ack_o(bus_ack_i), .rdata_o(bus_rdata_i),
        .bursts_o(bursts));

    task automatic chk(input string what, input logic [63:0] x, y);
        total_checks++;
        if (y !== x) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, x, y);
        end
    endtask : chk

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    // Waits for a condition sampled at an edge; a hang ends the run.
    task automatic until_hi(input int sel);
        logic s;
        for (int n = 0; n < 400; n++) begin
            @(posedge clock_i);
            s = sel == 0 ? fetch_ack_o : sel == 1 ? wb_ready_o :
                sel == 2 ? ram_ack_o : sel == 3 ? !bus_req_o :
                store_q.size() == 0;
            if (s === 1'b1) return;
        end
        chk("timeout", 64'h0, 64'h1);
        summarize();
    endtask : until_hi

    // Fetches one word and checks how many bursts it cost.
    task automatic fx(input logic [31:0] ad, input logic [15:0] d);
        logic [15:0] b0;
        b0 = bursts;
        bus_wait = 4'($urandom_range(3));
        fetch_q.push_back({ad[31:2], 2'h0} ^ 32'h5A5AC3C3);
        fetch_req_i = 1'b1;
        fetch_addr_i = ad;
        until_hi(0);
        #1 fetch_req_i = 1'b0;
        @(posedge clock_i);
        #1 chk("bursts", 64'(b0 + d), 64'(bursts));
    endtask : fx

    task automatic ram_op(input logic we, err, input logic [31:0] ad, d);
        ram_q.push_back({~we, err, d});
        ram_req_i = 1'b1;
        ram_we_i = we;
        ram_addr_i = ad;
        ram_wdata_i = d;
        until_hi(2);
        #1 ram_req_i = 1'b0;
        @(posedge clock_i);
        #1;
    endtask : ram_op

    task automatic push(input int cnt);
        wb_req_i = 1'b1;
        for (int i = 0; i < cnt; i++) begin
            wb_addr_i = {30'($urandom), 2'h0};
            wb_data_i = $urandom;
            store_q.push_back({wb_addr_i, wb_data_i});
            chk("wb_ready", 64'h1, 64'(wb_ready_o));
            until_hi(1);
            #1;
        end
        wb_req_i = 1'b0;
    endtask : push

    function automatic logic [31:0] mk(input logic [7:0] i);
        return {1'b0, 19'($urandom), i, 2'($urandom), 2'h0};
    endfunction : mk

    // Results arrive here in the order the drivers queued them.
    always @(posedge clock_i) begin
        if (fetch_ack_o === 1'b1) begin
            chk("fetch_data", 64'(fetch_q.pop_front()), 64'(fetch_data_o));
        end
        if (bus_req_o === 1'b1 && bus_we_o === 1'b1 && bus_ack_i === 1'b1) begin
            chk("store", store_q.pop_front(), {bus_addr_o, bus_wdata_o});
        end
        if (ram_ack_o === 1'b1) begin
            r = ram_q.pop_front();
            chk("ram", 64'(r[32:0]),
                64'({ram_err_o, r[33] ? ram_rdata_o : r[31:0]}));
        end
    end

    initial begin
        void'($urandom(38174));
        repeat (3) @(posedge clock_i);
        #1 chk("reset_out", 64'h0, 64'({fetch_ack_o, bus_req_o,
            wb_ready_o, ram_ack_o}));
        repeat (3) @(posedge clock_i);
        #1 rst_n_i = 1'b1;
        @(posedge clock_i);
        #1 chk("wb_ready", 64'h1, 64'(wb_ready_o));
        $display("test reset done");
        a = mk(8'($urandom));
        fx(a, 16'h0);
        fx(a, 16'h0);
        ram_op(1'b1, 1'b0, 32'hFFE01FFC, 32'h1234ABCD);
        ram_op(1'b1, 1'b0, 32'hFFE027FC, 32'h0F0F5A5A);
        ram_op(1'b0, 1'b0, 32'hFFE01FFC, 32'h1234ABCD);
        ram_op(1'b0, 1'b1, 32'hFFE02800, 32'h0);
        dcache_enable_bit_i = 1'b1;
        ram_op(1'b0, 1'b1, 32'hFFE02000, 32'h0);
        ram_op(1'b0, 1'b0, 32'hFFE01FFC, 32'h1234ABCD);
        icache_enable_bit_i = 1'b1;
        ram_op(1'b0, 1'b1, 32'hFFE00000, 32'h0);
        dcache_enable_bit_i = 1'b0;
        ram_op(1'b0, 1'b1, 32'hFFE00000, 32'h0);
        ram_op(1'b0, 1'b0, 32'hFFE027FC, 32'h0F0F5A5A);
        $display("test ram map done");
        ix = 8'($urandom);
        a = mk(ix);
        b = mk(ix);
        c = mk(ix);
        fx(a, 16'h1);
        fx(a ^ 32'h4, 16'h0);
        fx(a ^ 32'h8, 16'h0);
        fx(a ^ 32'hC, 16'h0);
        fx(b, 16'h1);
        fx(a, 16'h0);
        fx(c, 16'h1);
        fx(a, 16'h0);
        fx(b, 16'h1);
        fx(a ^ 32'h10, 16'h1);
        $display("test hit miss done");
        ix = ix + 8'h2;
        e = mk(ix);
        f = mk(ix);
        g = mk(ix);
        h = mk(ix);
        fill_lock_i = 1'b1;
        fx(e, 16'h1);
        until_hi(3);
        #1 fill_lock_i = 1'b0;
        fx(f, 16'h1);
        fx(g, 16'h1);
        fx(e, 16'h0);
        fx(g, 16'h0);
        fx(h, 16'h1);
        fx(e, 16'h0);
        fx(g, 16'h1);
        unlock_all_i = 1'b1;
        @(posedge clock_i);
        #1 unlock_all_i = 1'b0;
        fx(f, 16'h1);
        fx(e, 16'h1);
        fx(a | 32'h80000000, 16'h0);
        fx(a | 32'h80000000, 16'h0);
        $display("test lock uncached done");
        until_hi(3);
        #1 bus_wait = 4'h6;
        push(8);
        until_hi(4);
        repeat (3) @(posedge clock_i);
        #1 rst_n_i = 1'b0;
        repeat (2) @(posedge clock_i);
        #1 rst_n_i = 1'b1;
        fx(a, 16'h1);
        $display("test store reset done");
        summarize();
    end
endmodule : instruction_cache_onchip_ram_test

// >>> src/icor_cache.sv
// Purpose: Two-way instruction cache with on-chip RAM fallback and
//          an eight-word store buffer on the internal bus.
// Assumes: Fetch and bus partners run on clock_i; one fetch at a time.
// Notes:   Overview of operation follows.
`timescale 1ns/100ps

module icor_cache #(
    parameter int unsigned WBUF_DEPTH = 8,
    parameter int unsigned DRAM_WORDS = 512
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Enables and lock control
    input wire logic icache_enable_bit_i,
    input wire logic dcache_enable_bit_i,
    input wire logic fill_lock_i,
    input wire logic unlock_all_i,
    // Instruction fetch port
    input wire logic fetch_req_i,
    input wire logic [31:0] fetch_addr_i,
    output logic fetch_ack_o,
    output logic [31:0] fetch_data_o,
    // Internal bus master
    output logic bus_req_o,
    output logic bus_we_o,
    output logic bus_burst_o,
    output logic [31:0] bus_addr_o,
    output logic [31:0] bus_wdata_o,
    input wire logic bus_ack_i,
    input wire logic [31:0] bus_rdata_i,
    // Store buffer input
    input wire logic wb_req_i,
    input wire logic [31:0] wb_addr_i,
    input wire logic [31:0] wb_data_i,
    output logic wb_ready_o,
    // On-chip RAM port
    input wire logic ram_req_i,
    input wire logic ram_we_i,
    input wire logic [31:0] ram_addr_i,
    input wire logic [31:0] ram_wdata_i,
    output logic ram_ack_o,
    output logic ram_err_o,
    output logic [31:0] ram_rdata_o
);

    localparam int unsigned WB_AW = $clog2(WBUF_DEPTH);
    localparam int unsigned DR_AW = $clog2(DRAM_WORDS);

    // Refuse shapes the pointer arithmetic cannot serve.
    if (WBUF_DEPTH < 2 || (1 << WB_AW) != WBUF_DEPTH) begin : g_chk_wb
        $error("WBUF_DEPTH must be a power of two, at least 2");
    end
    if (DRAM_WORDS * 4 != icor_pkg::DRAM_BYTES) begin : g_chk_dr
        $error("DRAM_WORDS must cover the data RAM window");
    end

    // ************************************************************
    // Storage
    // ************************************************************
    logic [31:0] mem [0:2047];
    logic [31:0] dram [0:DRAM_WORDS-1];
    logic [icor_pkg::TAG_W-1:0] tags [0:511];
    logic [1:0] valid [0:icor_pkg::SETS-1];
    logic [1:0] lock [0:icor_pkg::SETS-1];
    logic [icor_pkg::SETS-1:0] lru;
    logic [31:0] wb_addr [0:WBUF_DEPTH-1];
    logic [31:0] wb_data [0:WBUF_DEPTH-1];

    // ************************************************************
    // Control state
    // ************************************************************
    icor_pkg::icor_state_t state;
    logic [31:0] miss_addr;
    logic [1:0] beat;
    logic alloc;
    logic vic_way;
    logic [WB_AW-1:0] wb_head;
    logic [WB_AW-1:0] wb_tail;
    logic [WB_AW:0] wb_count;

    // Set index of an address.
    function automatic logic [7:0] set_of(input logic [31:0] a);
        set_of = a[icor_pkg::IDX_MSB:icor_pkg::IDX_LSB];
    endfunction : set_of

    // Word slot in the flat array for way, set and word.
    function automatic logic [10:0] slot(input logic w,
                                         input logic [7:0] s,
                                         input logic [1:0] k);
        slot = {w, s, k};
    endfunction : slot

    // ************************************************************
    // Lookup and victim choice
    // ************************************************************
    logic [7:0] f_set;
    logic [icor_pkg::TAG_W-1:0] f_tag;
    logic [1:0] f_word;
    logic [1:0] way_hit;
    logic hit;
    logic hit_way;
    logic cacheable;
    logic take;
    logic fill_beat;
    logic last_beat;
    logic [7:0] m_set;
    logic [1:0] m_word;
    logic next_alloc;
    logic next_vic;

    assign f_set = set_of(fetch_addr_i);
    assign f_tag = fetch_addr_i[icor_pkg::TAG_MSB:icor_pkg::TAG_LSB];
    assign f_word = fetch_addr_i[icor_pkg::WSEL_MSB:icor_pkg::WSEL_LSB];
    // Both tags compare at once; a valid match is a hit.
    assign way_hit[0] = valid[f_set][0] &&
                        tags[{1'b0, f_set}] == f_tag;
    assign way_hit[1] = valid[f_set][1] &&
                        tags[{1'b1, f_set}] == f_tag;
    assign hit = |way_hit;
    assign hit_way = way_hit[1];
    // Disabled cache or bit 31 set bypasses lookup entirely.
    assign cacheable = icache_enable_bit_i &&
                       !fetch_addr_i[icor_pkg::NC_BIT];
    assign take = state == icor_pkg::ST_IDLE && fetch_req_i &&
                  !fetch_ack_o;
    assign fill_beat = state == icor_pkg::ST_FILL && bus_ack_i;
    assign last_beat = fill_beat && beat == icor_pkg::LAST_BEAT;
    assign m_set = set_of(miss_addr);
    // Beat n carries the word n places after the critical one.
    assign m_word = miss_addr[icor_pkg::WSEL_MSB:icor_pkg::WSEL_LSB]
                    + beat;

    // Invalid unlocked way first, then LRU way, never a locked one.
    always_comb begin
        next_alloc = 1'b1;
        next_vic = 1'b0;
        if (!valid[f_set][0] && !lock[f_set][0]) begin
            next_vic = 1'b0;
        end else if (!valid[f_set][1] && !lock[f_set][1]) begin
            next_vic = 1'b1;
        end else if (!lock[f_set][lru[f_set]]) begin
            next_vic = lru[f_set];
        end else if (!lock[f_set][!lru[f_set]]) begin
            next_vic = !lru[f_set];
        end else begin
            next_alloc = 1'b0;
        end
    end

    // ************************************************************
    // Controller and bus master
    // ************************************************************
    // Fetches win the bus over store draining so the core stalls least.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state <= icor_pkg::ST_IDLE;
            bus_req_o <= 1'b0;
            bus_we_o <= 1'b0;
            bus_burst_o <= 1'b0;
            bus_addr_o <= 32'h00000000;
            bus_wdata_o <= 32'h00000000;
            miss_addr <= 32'h00000000;
            beat <= 2'h0;
            alloc <= 1'b0;
            vic_way <= 1'b0;
        end else begin
            case (state)
                icor_pkg::ST_IDLE: begin
                    if (take && !(cacheable && hit)) begin
                        // Miss sends the exact word address out.
                        bus_req_o <= 1'b1;
                        bus_we_o <= 1'b0;
                        bus_burst_o <= cacheable;
                        bus_addr_o <= {fetch_addr_i[31:2], 2'h0};
                        miss_addr <= fetch_addr_i;
                        beat <= 2'h0;
                        alloc <= cacheable && next_alloc;
                        vic_way <= next_vic;
                        state <= cacheable ? icor_pkg::ST_FILL
                                           : icor_pkg::ST_SINGLE;
                    end else if (!take && wb_count != '0) begin
                        bus_req_o <= 1'b1;
                        bus_we_o <= 1'b1;
                        bus_burst_o <= 1'b0;
                        bus_addr_o <= wb_addr[wb_head];
                        bus_wdata_o <= wb_data[wb_head];
                        state <= icor_pkg::ST_DRAIN;
                    end
                end
                icor_pkg::ST_FILL: begin
                    if (fill_beat) begin
                        beat <= beat + 2'h1;
                    end
                    if (last_beat) begin
                        bus_req_o <= 1'b0;
                        bus_burst_o <= 1'b0;
                        state <= icor_pkg::ST_IDLE;
                    end
                end
                icor_pkg::ST_SINGLE, icor_pkg::ST_DRAIN: begin
                    if (bus_ack_i) begin
                        bus_req_o <= 1'b0;
                        bus_we_o <= 1'b0;
                        state <= icor_pkg::ST_IDLE;
                    end
                end
                default: begin
                    bus_req_o <= 1'b0;
                    state <= icor_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Fetch answer
    // ************************************************************
    // One-cycle ack; the critical fill word is passed on at once.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            fetch_ack_o <= 1'b0;
            fetch_data_o <= 32'h00000000;
        end else begin
            fetch_ack_o <= 1'b0;
            if (take && cacheable && hit) begin
                fetch_ack_o <= 1'b1;
                fetch_data_o <= mem[slot(hit_way, f_set, f_word)];
            end else if (fill_beat && beat == 2'h0) begin
                fetch_ack_o <= 1'b1;
                fetch_data_o <= bus_rdata_i;
            end else if (state == icor_pkg::ST_SINGLE && bus_ack_i) begin
                fetch_ack_o <= 1'b1;
                fetch_data_o <= bus_rdata_i;
            end
        end
    end

    // ************************************************************
    // Tags, valid, lock and LRU
    // ************************************************************
    // Disabling the cache also drops every line, since RAM writes
    // would otherwise corrupt lines that still look valid.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i || !icache_enable_bit_i) begin
            for (int i = 0; i < icor_pkg::SETS; i++) begin
                valid[i] <= icor_pkg::VALID_RST;
                lock[i] <= icor_pkg::LOCK_RST;
                lru[i] <= icor_pkg::LRU_RST;
            end
        end else begin
            if (unlock_all_i) begin
                for (int i = 0; i < icor_pkg::SETS; i++) begin
                    lock[i] <= icor_pkg::LOCK_RST;
                end
            end
            if (take && cacheable && hit) begin
                lru[f_set] <= !hit_way;
            end
            if (last_beat && alloc) begin
                valid[m_set][vic_way] <= 1'b1;
                tags[{vic_way, m_set}] <=
                    miss_addr[icor_pkg::TAG_MSB:icor_pkg::TAG_LSB];
                lru[m_set] <= !vic_way;
                // A lock landing with unlock-all wins, as set beats clear.
                if (fill_lock_i) begin
                    lock[m_set][vic_way] <= 1'b1;
                end
            end
        end
    end

    // ************************************************************
    // Data arrays and on-chip RAM port
    // ************************************************************
    logic [31:0] i_off;
    logic [31:0] d_off;
    logic i_sel;
    logic d_sel;

    assign i_off = ram_addr_i - icor_pkg::IRAM_BASE;
    assign d_off = ram_addr_i - icor_pkg::DRAM_BASE;
    // Each region exists only while its cache is off.
    assign i_sel = !icache_enable_bit_i &&
                   i_off < icor_pkg::IRAM_BYTES;
    assign d_sel = !dcache_enable_bit_i &&
                   d_off < icor_pkg::DRAM_BYTES;

    // Fill words and instruction RAM stores share the instruction array.
    always_ff @(posedge clock_i) begin
        if (fill_beat && alloc) begin
            mem[slot(vic_way, m_set, m_word)] <= bus_rdata_i;
        end else if (ram_req_i && !ram_ack_o && ram_we_i && i_sel) begin
            mem[i_off[12:2]] <= ram_wdata_i;
        end
        if (ram_req_i && !ram_ack_o && ram_we_i && d_sel) begin
            dram[d_off[DR_AW+1:2]] <= ram_wdata_i;
        end
    end

    // Unmapped RAM accesses still answer, flagged as errors.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ram_ack_o <= 1'b0;
            ram_err_o <= 1'b0;
            ram_rdata_o <= 32'h00000000;
        end else begin
            ram_ack_o <= ram_req_i && !ram_ack_o;
            ram_err_o <= ram_req_i && !ram_ack_o && !i_sel && !d_sel;
            if (ram_req_i && !ram_ack_o) begin
                ram_rdata_o <= i_sel ? mem[i_off[12:2]]
                             : d_sel ? dram[d_off[DR_AW+1:2]]
                             : 32'h00000000;
            end
        end
    end

    // ************************************************************
    // Store buffer
    // ************************************************************
    logic wb_push;
    logic wb_pop;
    logic [WB_AW:0] next_wb_count;

    assign wb_push = wb_req_i && wb_ready_o;
    assign wb_pop = state == icor_pkg::ST_DRAIN && bus_ack_i;
    assign next_wb_count = wb_count + (WB_AW+1)'(wb_push)
                           - (WB_AW+1)'(wb_pop);

    // Ready is registered from the next count, so it never lies.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            wb_head <= '0;
            wb_tail <= '0;
            wb_count <= '0;
            wb_ready_o <= 1'b0;
        end else begin
            if (wb_push) begin
                wb_addr[wb_tail] <= wb_addr_i;
                wb_data[wb_tail] <= wb_data_i;
                wb_tail <= wb_tail + 1'b1;
            end
            if (wb_pop) begin
                wb_head <= wb_head + 1'b1;
            end
            wb_count <= next_wb_count;
            wb_ready_o <= next_wb_count < (WB_AW+1)'(WBUF_DEPTH);
        end
    end

endmodule : icor_cache

// >>> src/icor_pkg.sv
// Purpose: Shared constants and types for the instruction cache block.
// Assumes: 32-bit byte addresses, 32-bit words.
// Notes:   Every offset, field position and valid, lock and LRU reset value lives here.

package icor_pkg;

    // ************************************************************
    // Geometry and address fields
    // ************************************************************
    localparam int unsigned SETS = 256;
    localparam int unsigned WORDS = 4;
    localparam int unsigned TAG_W = 19;
    localparam int unsigned IDX_LSB = 4;
    localparam int unsigned IDX_MSB = 11;
    localparam int unsigned TAG_LSB = 12;
    localparam int unsigned TAG_MSB = 30;
    localparam int unsigned WSEL_LSB = 2;
    localparam int unsigned WSEL_MSB = 3;
    localparam int unsigned NC_BIT = 31;
    localparam logic [1:0] LAST_BEAT = 2'h3;

    // ************************************************************
    // On-chip RAM map
    // ************************************************************
    localparam logic [31:0] IRAM_BASE = 32'hFFE00000;
    localparam logic [31:0] IRAM_BYTES = 32'h00002000;
    localparam logic [31:0] DRAM_BASE = 32'hFFE02000;
    localparam logic [31:0] DRAM_BYTES = 32'h00000800;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [1:0] VALID_RST = 2'h0;
    localparam logic [1:0] LOCK_RST = 2'h0;
    localparam logic LRU_RST = 1'b0;

    // Controller states, one-hot.
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_FILL = 4'h2,
        ST_SINGLE = 4'h4,
        ST_DRAIN = 4'h8
    } icor_state_t;

endpackage : icor_pkg
